//--- inc/irda_link_defines.svh
// Timing, slot and field constants for the IR secondary link-state controller.
`ifndef IRDA_LINK_DEFINES_SVH
`define IRDA_LINK_DEFINES_SVH

`define CLK_FREQ_HZ 25000000
`define TICK_TIME_MS 1
`define TICK_CYCLES ((`CLK_FREQ_HZ / 1000) * `TICK_TIME_MS)
`define IDLE_TIMEOUT_S 10
`define IDLE_TIMEOUT_TICKS ((`IDLE_TIMEOUT_S * 1000) / `TICK_TIME_MS)

`define ANSWER_SLOT 3'h2
`define FIRST_SLOT 3'h0

`define RATE_BIT_9600 1
`define RATE_BIT_19200 2
`define RATE_BIT_38400 3
`define RATE_BIT_57600 4
`define RATE_BIT_115200 5
`define DEV_RATE_MASK 8'h3E

`endif

//--- inc/irda_link_pkg.sv
// Types shared by the IR secondary link-state controller.
package irda_link_pkg;

  typedef enum logic [3:0] {
    K_POLL, K_BCAST_ID, K_PARAMS, K_IAS_NAME, K_IAS_ADDR, K_IAS_CAPS,
    K_SVC_OPEN, K_DATA, K_SUPV, K_CLOSE
  } frame_kind_e;

  typedef enum logic [3:0] {
    R_XID, R_PARAMS, R_IAS_NAME, R_IAS_ADDR, R_IAS_CAPS, R_ACK,
    R_DATA, R_READY, R_REJECT
  } reply_kind_e;

  typedef enum logic [2:0] {
    RATE_9600, RATE_19200, RATE_38400, RATE_57600, RATE_115200
  } ir_rate_e;

  typedef enum logic [1:0] {
    ST_NDM, ST_DISC_PARAM, ST_DISC_IAS, ST_NCM
  } link_state_e;

  typedef struct packed {
    frame_kind_e kind;
    logic [2:0] slot;
    logic [7:0] rate_mask;
    logic crc_ok;
  } rx_frame_s;

  typedef struct packed {
    reply_kind_e kind;
    logic [7:0] rate_mask;
  } tx_reply_s;

endpackage : irda_link_pkg

//--- src/idle_timer.sv
// Inactivity timer: millisecond enable from a divider, then a tick count.
`timescale 1ns/1ps
module idle_timer #(
  parameter int TICK_CYCLES = 25000,
  parameter int TIMEOUT_TICKS = 10000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic kick,
  // Result
  output logic expired
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int TW = $clog2(TIMEOUT_TICKS + 1);

  logic [PW-1:0] pre_q;
  logic [TW-1:0] ticks_q;
  logic tick;

  assign tick = (pre_q == PW'(TICK_CYCLES - 1));

  // A kick or a low run input restarts both stages so the full span is measured.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= '0;
    end
    else if (!run || kick || tick)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_q + PW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ticks_q <= '0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (!run || kick)
      begin
        ticks_q <= '0;
      end
      else if (tick)
      begin
        if (ticks_q == TW'(TIMEOUT_TICKS - 1))
        begin
          ticks_q <= '0;
          expired <= 1'b1;
        end
        else
        begin
          ticks_q <= ticks_q + TW'(1);
        end
      end
    end
  end

endmodule : idle_timer

//--- src/irda_link_ctrl.sv
// Link-state controller of an IR serial-replacement secondary station.
//
// Summary of operation
// - Disconnect-mode polling runs at 9600 baud.
// - Always answer poll number two.
// - Answer slot two in every poll series.
// - Disconnect mode answers alone; host held off.
// - Enter discovery after own reply and broadcast.
// - No timeout forces disconnect mode elsewhere.
// - Exchange parameters at 9600, then highest common.
// - Never offer or accept above 115.2 kbaud.
// - Answer service name, address, capability queries.
// - Discovery answers alone; host held off.
// - Connected: accept IR or serial, never both.
// - Stop host serial while IR data arrives.
// - Check frames; reject those with errors.
// - Keep exchanging frames without user data.
// - Acknowledge close, then return to disconnect.
// - Ten seconds without frames returns to disconnect.
// - Carrier detect only while link established.
`timescale 1ns/1ps
`include "irda_link_defines.svh"
module irda_link_ctrl #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int TIMEOUT_TICKS = `IDLE_TIMEOUT_TICKS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Decoded frames from the IR receiver
  input wire logic RX_VALID,
  input wire irda_link_pkg::rx_frame_s RX_FRAME,
  // IR receiver activity pin
  input wire logic IR_RX_ACT,
  // Host has serial bytes waiting to go out
  input wire logic HOST_DATA_PEND,
  // Reply request to the IR transmitter
  output irda_link_pkg::tx_reply_s TX_FRAME,
  output logic TX_REQ,
  input wire logic TX_DONE,
  // Link status
  output irda_link_pkg::ir_rate_e IR_RATE,
  output irda_link_pkg::link_state_e LINK_MODE,
  output logic CARRIER_DET,
  // Host flow control and data path steering
  output logic HOST_STOP,
  output logic IR_DATA_EN,
  output logic SER_DATA_EN
);

  irda_link_pkg::link_state_e state_q;
  irda_link_pkg::ir_rate_e rate_q;
  irda_link_pkg::ir_rate_e rate_pend_q;
  logic busy_q;
  logic xid_sent_q;
  logic close_pend_q;
  logic param_pend_q;
  logic ir_s1_q;
  logic ir_s2_q;
  logic ir_s3_q;
  logic ir_act_q;
  logic take;
  logic good;
  logic timed_out;
  logic go;
  irda_link_pkg::reply_kind_e kind;
  irda_link_pkg::ir_rate_e best_rate;
  logic [7:0] common;

  // The pin is asynchronous; a level counts only once two later stages agree.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ir_s1_q <= 1'b0;
      ir_s2_q <= 1'b0;
      ir_s3_q <= 1'b0;
      ir_act_q <= 1'b0;
    end
    else
    begin
      ir_s1_q <= IR_RX_ACT;
      ir_s2_q <= ir_s1_q;
      ir_s3_q <= ir_s2_q;
      if (ir_s2_q == ir_s3_q)
      begin
        ir_act_q <= ir_s3_q;
      end
    end
  end

  // Half duplex: a frame arriving while our own reply is in flight is dropped.
  assign take = RX_VALID && !busy_q;
  assign good = take && RX_FRAME.crc_ok;
  assign common = RX_FRAME.rate_mask & `DEV_RATE_MASK;

  // Highest rate both ends support; 9600 is the floor.
  always_comb
  begin
    best_rate = irda_link_pkg::RATE_9600;
    if (common[`RATE_BIT_115200])
    begin
      best_rate = irda_link_pkg::RATE_115200;
    end
    else if (common[`RATE_BIT_57600])
    begin
      best_rate = irda_link_pkg::RATE_57600;
    end
    else if (common[`RATE_BIT_38400])
    begin
      best_rate = irda_link_pkg::RATE_38400;
    end
    else if (common[`RATE_BIT_19200])
    begin
      best_rate = irda_link_pkg::RATE_19200;
    end
  end

  // Reply selection per mode; only the connected-mode data reply looks at the host.
  always_comb
  begin
    go = 1'b0;
    kind = irda_link_pkg::R_ACK;
    case (state_q)
      irda_link_pkg::ST_NDM:
      begin
        if (good && RX_FRAME.kind == irda_link_pkg::K_POLL && RX_FRAME.slot == `ANSWER_SLOT)
        begin
          go = 1'b1;
          kind = irda_link_pkg::R_XID;
        end
      end
      irda_link_pkg::ST_DISC_PARAM:
      begin
        if (good && RX_FRAME.kind == irda_link_pkg::K_PARAMS)
        begin
          go = 1'b1;
          kind = irda_link_pkg::R_PARAMS;
        end
      end
      irda_link_pkg::ST_DISC_IAS:
      begin
        if (good)
        begin
          go = 1'b1;
          case (RX_FRAME.kind)
            irda_link_pkg::K_IAS_NAME: kind = irda_link_pkg::R_IAS_NAME;
            irda_link_pkg::K_IAS_ADDR: kind = irda_link_pkg::R_IAS_ADDR;
            irda_link_pkg::K_IAS_CAPS: kind = irda_link_pkg::R_IAS_CAPS;
            irda_link_pkg::K_SVC_OPEN: kind = irda_link_pkg::R_ACK;
            default: go = 1'b0;
          endcase
        end
      end
      default:
      begin
        if (take && !RX_FRAME.crc_ok)
        begin
          go = 1'b1;
          kind = irda_link_pkg::R_REJECT;
        end
        else if (good)
        begin
          go = 1'b1;
          if (RX_FRAME.kind == irda_link_pkg::K_CLOSE)
          begin
            kind = irda_link_pkg::R_ACK;
          end
          else if (HOST_DATA_PEND && !ir_act_q)
          begin
            kind = irda_link_pkg::R_DATA;
          end
          else
          begin
            kind = irda_link_pkg::R_READY;
          end
        end
      end
    endcase
  end

  // Reply request is a one-cycle pulse; busy holds until the transmitter ends.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      TX_REQ <= 1'b0;
      TX_FRAME <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      TX_REQ <= go;
      if (go)
      begin
        TX_FRAME.kind <= kind;
        TX_FRAME.rate_mask <= `DEV_RATE_MASK;
        busy_q <= 1'b1;
      end
      else if (TX_DONE)
      begin
        busy_q <= 1'b0;
      end
    end
  end

  // Set wins over the slot-zero clear: a new series starting at slot two still counts.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      xid_sent_q <= 1'b0;
    end
    else if (state_q != irda_link_pkg::ST_NDM)
    begin
      xid_sent_q <= 1'b0;
    end
    else if (go)
    begin
      xid_sent_q <= 1'b1;
    end
    else if (good && RX_FRAME.kind == irda_link_pkg::K_POLL && RX_FRAME.slot == `FIRST_SLOT)
    begin
      xid_sent_q <= 1'b0;
    end
  end

  idle_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .TIMEOUT_TICKS(TIMEOUT_TICKS)
  ) u_idle (
    .clk(CLK),
    .rst(RST),
    .run(state_q == irda_link_pkg::ST_NCM),
    .kick(RX_VALID),
    .expired(timed_out)
  );

  // Mode sequencing. Disconnect mode has no timed exit.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= irda_link_pkg::ST_NDM;
      rate_q <= irda_link_pkg::RATE_9600;
      rate_pend_q <= irda_link_pkg::RATE_9600;
      close_pend_q <= 1'b0;
      param_pend_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        irda_link_pkg::ST_NDM:
        begin
          rate_q <= irda_link_pkg::RATE_9600;
          if (good && RX_FRAME.kind == irda_link_pkg::K_BCAST_ID && xid_sent_q)
          begin
            state_q <= irda_link_pkg::ST_DISC_PARAM;
          end
        end
        irda_link_pkg::ST_DISC_PARAM:
        begin
          // The new rate waits until our parameter reply has gone out at 9600.
          if (go)
          begin
            rate_pend_q <= best_rate;
            param_pend_q <= 1'b1;
          end
          else if (param_pend_q && TX_DONE)
          begin
            rate_q <= rate_pend_q;
            param_pend_q <= 1'b0;
            state_q <= irda_link_pkg::ST_DISC_IAS;
          end
        end
        irda_link_pkg::ST_DISC_IAS:
        begin
          if (good && RX_FRAME.kind == irda_link_pkg::K_SVC_OPEN)
          begin
            state_q <= irda_link_pkg::ST_NCM;
          end
        end
        default:
        begin
          if (timed_out)
          begin
            state_q <= irda_link_pkg::ST_NDM;
            rate_q <= irda_link_pkg::RATE_9600;
            close_pend_q <= 1'b0;
          end
          else if (go && kind == irda_link_pkg::R_ACK)
          begin
            close_pend_q <= 1'b1;
          end
          else if (close_pend_q && TX_DONE)
          begin
            close_pend_q <= 1'b0;
            state_q <= irda_link_pkg::ST_NDM;
            rate_q <= irda_link_pkg::RATE_9600;
          end
        end
      endcase
    end
  end

  // Host flow control and exclusive data path selection.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      HOST_STOP <= 1'b1;
      IR_DATA_EN <= 1'b0;
      SER_DATA_EN <= 1'b0;
      CARRIER_DET <= 1'b0;
      LINK_MODE <= irda_link_pkg::ST_NDM;
      IR_RATE <= irda_link_pkg::RATE_9600;
    end
    else
    begin
      HOST_STOP <= (state_q != irda_link_pkg::ST_NCM) || ir_act_q;
      IR_DATA_EN <= (state_q == irda_link_pkg::ST_NCM) && ir_act_q;
      SER_DATA_EN <= (state_q == irda_link_pkg::ST_NCM) && !ir_act_q;
      CARRIER_DET <= (state_q == irda_link_pkg::ST_NCM);
      LINK_MODE <= state_q;
      IR_RATE <= rate_q;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_close_taken;
    (state_q == irda_link_pkg::ST_NCM) && good && !timed_out &&
      (RX_FRAME.kind == irda_link_pkg::K_CLOSE);
  endsequence

  sequence s_ack_out;
    TX_REQ && (TX_FRAME.kind == irda_link_pkg::R_ACK);
  endsequence

  a_slot_two_reply: assert property (
    ((state_q == irda_link_pkg::ST_NDM) && good && (RX_FRAME.kind == irda_link_pkg::K_POLL)
      && (RX_FRAME.slot == `ANSWER_SLOT))
    |=> TX_REQ && (TX_FRAME.kind == irda_link_pkg::R_XID))
    else $error("poll two not answered");

  a_ndm_base_rate: assert property (
    (state_q == irda_link_pkg::ST_NDM) ##1 (state_q == irda_link_pkg::ST_NDM)
    |-> (rate_q == irda_link_pkg::RATE_9600))
    else $error("disconnect mode not at 9600");

  a_disc_entry: assert property (
    $rose(state_q == irda_link_pkg::ST_DISC_PARAM) |-> $past(xid_sent_q))
    else $error("discovery entered without own reply");

  a_ndm_hold: assert property (
    (state_q == irda_link_pkg::ST_NDM) &&
      !(good && RX_FRAME.kind == irda_link_pkg::K_BCAST_ID)
    |=> (state_q == irda_link_pkg::ST_NDM))
    else $error("left disconnect mode without broadcast");

  a_host_held: assert property (
    (state_q != irda_link_pkg::ST_NCM) |=> HOST_STOP)
    else $error("host released outside connected mode");

  a_rate_cap: assert property (
    (state_q == irda_link_pkg::ST_DISC_PARAM) && go && (RX_FRAME.rate_mask[5:1] == 5'h00)
    |=> (rate_pend_q == irda_link_pkg::RATE_9600) && (TX_FRAME.rate_mask[7:6] == 2'b00))
    else $error("rate above limit offered");

  a_path_exclusive: assert property (
    !(IR_DATA_EN && SER_DATA_EN))
    else $error("both data paths enabled");

  a_stop_on_ir: assert property (
    ir_act_q |=> HOST_STOP ##0 !SER_DATA_EN)
    else $error("host not stopped during IR receive");

  a_reject_bad: assert property (
    (state_q == irda_link_pkg::ST_NCM) && take && !RX_FRAME.crc_ok
    |=> TX_REQ && (TX_FRAME.kind == irda_link_pkg::R_REJECT))
    else $error("errored frame not rejected");

  a_keepalive: assert property (
    (state_q == irda_link_pkg::ST_NCM) && good && (RX_FRAME.kind == irda_link_pkg::K_SUPV)
    |=> TX_REQ)
    else $error("supervisory frame not answered");

  a_close_seq: assert property (
    s_close_taken ##1 s_ack_out ##0 (!TX_DONE && !timed_out) [*1] ##0 1'b1
    |-> (state_q == irda_link_pkg::ST_NCM))
    else $error("close not acknowledged before leaving");

  a_close_exit: assert property (
    close_pend_q && TX_DONE && !timed_out && (state_q == irda_link_pkg::ST_NCM)
    |=> (state_q == irda_link_pkg::ST_NDM) ##1 !CARRIER_DET)
    else $error("no return after close");

  a_idle_exit: assert property (
    timed_out && (state_q == irda_link_pkg::ST_NCM) |=> (state_q == irda_link_pkg::ST_NDM))
    else $error("inactivity did not end link");

  a_cd_link: assert property (
    CARRIER_DET |-> $past(state_q == irda_link_pkg::ST_NCM))
    else $error("carrier detect without link");

endmodule : irda_link_ctrl

//--- test/primary_station_model.sv
// Behavioural primary station: sends decoded frames and completes device replies.
`timescale 1ns/1ps
module primary_station_model (
  // Clock
  input wire logic clk,
  // Frames toward the device
  output logic rx_valid,
  output irda_link_pkg::rx_frame_s rx_frame,
  // Reply completion
  input wire logic tx_req,
  output logic tx_done
);
  int done_delay = 1;

  initial
  begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_done = 1'b0;
  end

  // Air time of a reply varies, so completion comes promptly or late.
  always
  begin
    @(posedge clk);
    #1;
    if (tx_req === 1'b1)
    begin
      repeat (done_delay) @(posedge clk);
      #1 tx_done = 1'b1;
      @(posedge clk);
      #1 tx_done = 1'b0;
    end
  end

  // Between frames slot, rate mask and check flag carry noise, so nothing may lean on stale values.
  task send_frame(input irda_link_pkg::rx_frame_s f);
    @(posedge clk);
    #1 rx_valid = 1'b1;
    rx_frame = f;
    @(posedge clk);
    #1 rx_valid = 1'b0;
    rx_frame.slot = 3'($urandom);
    rx_frame.rate_mask = 8'($urandom);
    rx_frame.crc_ok = 1'($urandom);
  endtask : send_frame
endmodule : primary_station_model

//--- test/irda_link_ctrl_test.sv
// Self-checking bench for the IR secondary link-state controller.
`timescale 1ns/1ps
module irda_link_ctrl_test;
  localparam int TICKS = 4;
  localparam int TO_TICKS = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ir_act = 1'b0;
  logic pend = 1'b0;
  logic rx_valid, tx_req, tx_done, cd, host_stop, ir_en, ser_en, got;
  irda_link_pkg::rx_frame_s rx_frame;
  irda_link_pkg::tx_reply_s tx_frame, last_reply;
  irda_link_pkg::ir_rate_e rate;
  irda_link_pkg::link_state_e mode;
  int mismatches = 0;
  int total_checks = 0;
  int reply_cnt = 0;
  int done_cnt = 0;
  logic [7:0] masks [4] = '{8'hFE, 8'hC0, 8'h06, 8'h00};

  always #20 clk = ~clk;

  irda_link_ctrl #(.TICK_CYCLES(TICKS), .TIMEOUT_TICKS(TO_TICKS)) i_dut (
    .CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX_FRAME(rx_frame),
    .IR_RX_ACT(ir_act), .HOST_DATA_PEND(pend), .TX_FRAME(tx_frame),
    .TX_REQ(tx_req), .TX_DONE(tx_done), .IR_RATE(rate), .LINK_MODE(mode),
    .CARRIER_DET(cd), .HOST_STOP(host_stop), .IR_DATA_EN(ir_en), .SER_DATA_EN(ser_en)
  );

  primary_station_model i_peer (
    .clk(clk), .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_req(tx_req), .tx_done(tx_done)
  );

  always @(posedge clk)
  begin
    if (tx_req === 1'b1)
    begin
      reply_cnt++;
      last_reply = tx_frame;
    end
    if (tx_done === 1'b1)
      done_cnt++;
  end

  function automatic irda_link_pkg::ir_rate_e exp_rate(input logic [7:0] m);
    irda_link_pkg::ir_rate_e r;
    r = irda_link_pkg::RATE_9600;
    for (int b = 2; b <= 5; b++)
      if (m[b])
        r = irda_link_pkg::ir_rate_e'(b - 1);
    return r;
  endfunction : exp_rate

  task automatic check_mask(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_mask

  task automatic check_flag(input logic g, input logic e);
    check_mask({7'h00, g}, {7'h00, e});
  endtask : check_flag

  task automatic check_mode(input irda_link_pkg::link_state_e g, input irda_link_pkg::link_state_e e);
    check_mask(8'(g), 8'(e));
  endtask : check_mode

  task automatic check_rate(input irda_link_pkg::ir_rate_e g, input irda_link_pkg::ir_rate_e e);
    check_mask(8'(g), 8'(e));
  endtask : check_rate

  task automatic check_reply(input irda_link_pkg::reply_kind_e g, input irda_link_pkg::reply_kind_e e);
    check_mask(8'(g), 8'(e));
  endtask : check_reply

  // One frame from the primary, then wait until any reply has been completed.
  task automatic xfer(input irda_link_pkg::frame_kind_e k, input logic [2:0] s,
    input logic [7:0] m, input logic ok);
    int n;
    n = reply_cnt;
    i_peer.done_delay = 1 + int'($urandom % 8);
    i_peer.send_frame('{kind: k, slot: s, rate_mask: m, crc_ok: ok});
    repeat (2) @(posedge clk);
    #1 got = (reply_cnt != n);
    for (int i = 0; i < 30 && done_cnt != reply_cnt; i++)
    begin
      @(posedge clk);
      #1;
    end
    check_flag(1'(done_cnt == reply_cnt), 1'b1);
    repeat (3) @(posedge clk);
    #1;
  endtask : xfer

  task automatic link_cycle(input int c);
    logic [7:0] m;
    logic ok;
    int n;
    irda_link_pkg::frame_kind_e k;
    irda_link_pkg::reply_kind_e e;
    m = (c == 3) ? 8'($urandom) : masks[c];
    xfer(irda_link_pkg::K_POLL, 3'h0, m, 1'b1);
    xfer(irda_link_pkg::K_BCAST_ID, 3'h0, m, 1'b1);
    repeat (50) @(posedge clk);
    #1;
    check_mode(mode, irda_link_pkg::ST_NDM);
    for (int r = 0; r < 2; r++)
    begin
      n = ($urandom % 2) ? 8 : 6;
      for (int s = 0; s < n; s++)
      begin
        xfer(irda_link_pkg::K_POLL, 3'(s), m, 1'b1);
        check_flag(got, 1'(s == 2));
        check_flag(host_stop, 1'b1);
      end
      check_reply(last_reply.kind, irda_link_pkg::R_XID);
    end
    xfer(irda_link_pkg::K_BCAST_ID, 3'h0, m, 1'b1);
    check_mode(mode, irda_link_pkg::ST_DISC_PARAM);
    check_rate(rate, irda_link_pkg::RATE_9600);
    xfer(irda_link_pkg::K_PARAMS, 3'h0, m, 1'b1);
    check_reply(last_reply.kind, irda_link_pkg::R_PARAMS);
    check_mask(last_reply.rate_mask, 8'h3E);
    check_rate(rate, exp_rate(m));
    for (int q = 0; q < 3; q++)
    begin
      k = irda_link_pkg::frame_kind_e'(irda_link_pkg::K_IAS_NAME + q);
      e = irda_link_pkg::reply_kind_e'(irda_link_pkg::R_IAS_NAME + q);
      xfer(k, 3'h0, m, 1'b1);
      check_reply(last_reply.kind, e);
      check_flag(host_stop, 1'b1);
      check_flag(cd, 1'b0);
    end
    xfer(irda_link_pkg::K_SVC_OPEN, 3'h0, m, 1'b1);
    check_reply(last_reply.kind, irda_link_pkg::R_ACK);
    check_mode(mode, irda_link_pkg::ST_NCM);
    check_flag(cd, 1'b1);
    check_flag(host_stop, 1'b0);
    check_flag(ser_en, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      // The first frame always fails its check so the reject path is hit in every cycle.
      ok = (i == 0) ? 1'b0 : 1'(($urandom % 4) != 0);
      pend = 1'($urandom % 2);
      k = ($urandom % 2) ? irda_link_pkg::K_DATA : irda_link_pkg::K_SUPV;
      e = !ok ? irda_link_pkg::R_REJECT : (pend ? irda_link_pkg::R_DATA : irda_link_pkg::R_READY);
      xfer(k, 3'($urandom), m, ok);
      check_reply(last_reply.kind, e);
    end
    pend = 1'b0;
    ir_act = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check_flag(host_stop, 1'b1);
    check_flag(ir_en, 1'b1);
    check_flag(ser_en, 1'b0);
    ir_act = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check_flag(host_stop, 1'b0);
    if (c % 2 == 0)
    begin
      xfer(irda_link_pkg::K_CLOSE, 3'h0, m, 1'b1);
      check_reply(last_reply.kind, irda_link_pkg::R_ACK);
    end
    else
    begin
      xfer(irda_link_pkg::K_SUPV, 3'h0, m, 1'b1);
      repeat (8) @(posedge clk);
      #1;
      check_mode(mode, irda_link_pkg::ST_NCM);
      repeat (TICKS * TO_TICKS) @(posedge clk);
      #1;
    end
    check_mode(mode, irda_link_pkg::ST_NDM);
    check_flag(cd, 1'b0);
    check_flag(host_stop, 1'b1);
    check_rate(rate, irda_link_pkg::RATE_9600);
    $display("link cycle %0d ended, checks %0d", c, total_checks);
  endtask : link_cycle

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial
  begin
    void'($urandom(68));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    check_flag(host_stop, 1'b1);
    check_flag(cd, 1'b0);
    check_flag(tx_req, 1'b0);
    check_rate(rate, irda_link_pkg::RATE_9600);
    check_mode(mode, irda_link_pkg::ST_NDM);
    for (int c = 0; c < 4; c++)
      link_cycle(c);
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : irda_link_ctrl_test
